// [shared/aux_conv_pkg.sv]
// shared constants, register map and types for the auxiliary converter control block
package aux_conv_pkg;

  // bus geometry: byte address is four times the register index
  localparam int unsigned ADR_W      = 10;
  localparam int unsigned DAT_W      = 32;
  localparam int unsigned RESULT_W   = 12;
  localparam int unsigned LEN_W      = 6;
  localparam int unsigned DIV_W      = 8;

  // register indices
  localparam logic [7:0]  IDX_CONFIG = 8'h77;   // config, any write with byte lane 0 selected starts a conversion
  localparam logic [7:0]  IDX_HIGH   = 8'h78;   // result bits 11:4
  localparam logic [7:0]  IDX_LOW    = 8'h79;   // result bits 3:0 and completion flag
  localparam logic [7:0]  IDX_CTRL   = 8'h7a;   // clock enable, converter reset, divider

  // field positions
  localparam int unsigned LOW_RES_LSB  = 4;     // result low nibble at 7:4
  localparam int unsigned LOW_DONE_BIT = 3;     // completion flag
  localparam int unsigned CTRL_EN_BIT  = 7;
  localparam int unsigned CTRL_RST_BIT = 6;

  // reset values
  localparam logic [7:0]  CONFIG_RST = 8'h00;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic        DONE_RST   = 1'b0;    // nothing valid until a first conversion

  // conversion lengths in conversion-clock cycles
  localparam logic [LEN_W-1:0] LEN_20 = 6'h14;
  localparam logic [LEN_W-1:0] LEN_22 = 6'h16;
  localparam logic [LEN_W-1:0] LEN_26 = 6'h1a;
  localparam logic [LEN_W-1:0] LEN_34 = 6'h22;

  // configuration register layout
  typedef struct packed {
    logic [1:0] length_sel;                     // conversion_length_sel
    logic [2:0] unused;
    logic [2:0] channel_sel;                    // input_channel_sel
  } config_t;

  // clock control register layout
  typedef struct packed {
    logic       clock_enable;                   // conversion_clock_enable
    logic       reset_bit;                      // converter_reset_bit
    logic [2:0] unused;
    logic [2:0] divider;                        // conversion_clock_divider
  } clk_ctrl_t;

  // sequencer states
  typedef enum logic [0:0] {
    ST_IDLE    = 1'b0,
    ST_CONVERT = 1'b1
  } conv_state_t;

  // cycles per conversion for a length code
  function automatic logic [LEN_W-1:0] conv_length(input logic [1:0] sel);
    case (sel)
      2'h0:    conv_length = LEN_20;
      2'h1:    conv_length = LEN_22;
      2'h2:    conv_length = LEN_26;
      default: conv_length = LEN_34;
    endcase
  endfunction : conv_length

  // last count of the divider: 000 -> 255 (divide 256) ... 111 -> 1 (divide 2)
  function automatic logic [DIV_W-1:0] div_last(input logic [2:0] sel);
    div_last = 8'hff >> sel;
  endfunction : div_last

endpackage : aux_conv_pkg

// [logic/aux_conv_clkdiv.sv]
// conversion clock divider producing a one-cycle enable pulse
`timescale 1ns/10ps
module aux_conv_clkdiv (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // control
  input  wire logic       i_enable,
  input  wire logic [2:0] i_div_sel,
  // conversion clock tick
  output logic            o_tick
);

  logic [aux_conv_pkg::DIV_W-1:0] count_q;   // position in the divide period
  logic [aux_conv_pkg::DIV_W-1:0] count_d;
  logic                           tick_q;    // one pulse per period
  logic                           tick_d;

  // next count: held at zero while the clock is stopped
  always_comb begin
    count_d = count_q;
    tick_d  = 1'b0;
    if (!i_enable) begin
      count_d = '0;                                                   // [R9]
    end else if (count_q >= aux_conv_pkg::div_last(i_div_sel)) begin
      // >= so a divider change mid-period never overruns the wrap
      count_d = '0;                                                   // [R8]
      tick_d  = 1'b1;
    end else begin
      count_d = count_q + 8'h01;
    end
  end

  // registers only
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= '0;
      tick_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      tick_q  <= tick_d;
    end
  end

  assign o_tick = tick_q;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // a divider change mid-period may wrap from a count above the new end point
  div_ratio_a: assert property (tick_q |-> $past(count_q) >= aux_conv_pkg::div_last($past(i_div_sel))) // [R8]
    else $error("tick not at end of divide period");
  div_stop_a: assert property (!i_enable |=> !tick_q ##1 !tick_q || i_enable) // [R9]
    else $error("tick while conversion clock disabled");

endmodule : aux_conv_clkdiv

// [logic/aux_conv_ctrl.sv]
// auxiliary converter conversion control with wishbone register slave
// Contract
// R1: length code 7:6 gives 20/22/26/34 cycles
// R2: config bits 2:0 select converter input
// R3: any config write starts a conversion; the code starts one only on writes with byte lane 0 selected
// R4: high register shows result bits 11:4
// R5: low register bits 7:4 show result 3:0
// R6: low register bit 3 is completion flag
// R7: start clears flag; finish sets flag, results
// R8: conversion clock divides main clock 256..2
// R9: enable bit stops or runs conversion clock
// R10: reset bit rising edge resets converter
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
module aux_conv_ctrl (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [9:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic [31:0]      o_wb_dat,
  // converter side
  input  wire logic [11:0] i_conv_result,
  output logic [2:0]       o_channel_sel,
  output logic             o_conv_start,
  output logic             o_conv_reset,
  output logic             o_conv_tick,
  output logic             o_busy
);

  // bus slave state
  logic        ack_q;                        // one-cycle acknowledge
  logic        ack_d;
  logic [31:0] rdat_q;                       // registered read data
  logic [31:0] rdat_d;

  // software registers
  aux_conv_pkg::config_t   cfg_q;            // length and channel
  aux_conv_pkg::config_t   cfg_d;
  aux_conv_pkg::clk_ctrl_t ctrl_q;           // clock enable, reset, divider
  aux_conv_pkg::clk_ctrl_t ctrl_d;

  // sequencer state
  aux_conv_pkg::conv_state_t       state_q;
  aux_conv_pkg::conv_state_t       state_d;
  logic [aux_conv_pkg::LEN_W-1:0]  remain_q; // ticks still to go
  logic [aux_conv_pkg::LEN_W-1:0]  remain_d;
  logic [11:0]                     result_q; // latest result
  logic [11:0]                     result_d;
  logic                            done_q;   // conversion_done_flag
  logic                            done_d;
  logic                            start_q;  // start pulse to converter
  logic                            start_d;
  logic                            creset_q; // reset pulse to converter
  logic                            creset_d;

  // decode helpers
  logic       take;                          // new request this cycle
  logic [7:0] index;                         // register index
  logic       wr_config;
  logic       wr_ctrl;
  logic       reset_edge;
  logic       tick;                          // conversion clock enable pulse

  assign take       = i_wb_cyc && i_wb_stb && !ack_q;
  assign index      = i_wb_adr[9:2];
  // a write lands only when the low byte lane is selected
  assign wr_config  = take && i_wb_we && i_wb_sel[0] && (index == aux_conv_pkg::IDX_CONFIG);
  assign wr_ctrl    = take && i_wb_we && i_wb_sel[0] && (index == aux_conv_pkg::IDX_CTRL);
  assign reset_edge = wr_ctrl && i_wb_dat[aux_conv_pkg::CTRL_RST_BIT] && !ctrl_q.reset_bit;

  // conversion clock divider
  aux_conv_clkdiv u_clkdiv (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_enable  (ctrl_q.clock_enable),
    .i_div_sel (ctrl_q.divider),
    .o_tick    (tick)
  );

  // bus slave: ack one cycle after the request, zero for unmapped indices
  always_comb begin
    ack_d  = take;
    rdat_d = rdat_q;
    cfg_d  = cfg_q;
    ctrl_d = ctrl_q;
    if (take) begin
      rdat_d = 32'h0000_0000;
      case (index)
        aux_conv_pkg::IDX_CONFIG: begin
          rdat_d[7:0] = cfg_q;
        end
        aux_conv_pkg::IDX_HIGH: begin
          rdat_d[7:0] = result_q[11:4];                               // [R4]
        end
        aux_conv_pkg::IDX_LOW: begin
          rdat_d[7:aux_conv_pkg::LOW_RES_LSB] = result_q[3:0];        // [R5]
          rdat_d[aux_conv_pkg::LOW_DONE_BIT]  = done_q;               // [R6]
        end
        aux_conv_pkg::IDX_CTRL: begin
          rdat_d[7:0] = ctrl_q;
        end
        default: begin
          rdat_d = 32'h0000_0000;                                     // unmapped reads zero
        end
      endcase
    end
    if (wr_config) begin
      cfg_d        = i_wb_dat[7:0];
      cfg_d.unused = 3'h0;                                            // unused bits read zero
    end
    if (wr_ctrl) begin
      ctrl_d        = i_wb_dat[7:0];
      ctrl_d.unused = 3'h0;
    end
  end

  // sequencer: start, count ticks, publish result
  always_comb begin
    state_d  = state_q;
    remain_d = remain_q;
    result_d = result_q;
    done_d   = done_q;
    start_d  = 1'b0;
    creset_d = reset_edge;                                            // [R10]
    case (state_q)
      aux_conv_pkg::ST_CONVERT: begin
        // ticks only arrive while the clock is enabled, so a stopped clock stalls here
        if (tick) begin
          if (remain_q == 6'h01) begin
            result_d = i_conv_result;                                 // [R7]
            done_d   = 1'b1;
            state_d  = aux_conv_pkg::ST_IDLE;
          end else begin
            remain_d = remain_q - 6'h01;
          end
        end
      end
      aux_conv_pkg::ST_IDLE: begin
        state_d = aux_conv_pkg::ST_IDLE;
      end
      default: begin
        state_d = aux_conv_pkg::ST_IDLE;
      end
    endcase
    // a converter reset abandons a running conversion; flag stays low unless it finishes in the same cycle
    if (reset_edge) begin
      state_d = aux_conv_pkg::ST_IDLE;                                // [R10]
    end
    // a start overrides everything: a finishing result is still stored
    if (wr_config) begin
      state_d  = aux_conv_pkg::ST_CONVERT;                            // [R3]
      remain_d = aux_conv_pkg::conv_length(i_wb_dat[7:6]);            // [R1]
      done_d   = 1'b0;                                                // [R7]
      start_d  = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q    <= 1'b0;
      rdat_q   <= 32'h0000_0000;
      cfg_q    <= aux_conv_pkg::CONFIG_RST;
      ctrl_q   <= aux_conv_pkg::CTRL_RST;
      state_q  <= aux_conv_pkg::ST_IDLE;
      remain_q <= 6'h00;
      result_q <= 12'h000;
      done_q   <= aux_conv_pkg::DONE_RST;
      start_q  <= 1'b0;
      creset_q <= 1'b0;
    end else begin
      ack_q    <= ack_d;
      rdat_q   <= rdat_d;
      cfg_q    <= cfg_d;
      ctrl_q   <= ctrl_d;
      state_q  <= state_d;
      remain_q <= remain_d;
      result_q <= result_d;
      done_q   <= done_d;
      start_q  <= start_d;
      creset_q <= creset_d;
    end
  end

  // outputs straight from flops
  assign o_wb_ack      = ack_q;
  assign o_wb_dat      = rdat_q;
  assign o_channel_sel = cfg_q.channel_sel;                           // [R2]
  assign o_conv_start  = start_q;
  assign o_conv_reset  = creset_q;
  assign o_conv_tick   = tick;
  assign o_busy        = (state_q == aux_conv_pkg::ST_CONVERT);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  len_load_a: assert property (wr_config |=> remain_q == aux_conv_pkg::conv_length($past(i_wb_dat[7:6]))) // [R1]
    else $error("conversion length not loaded from code");
  chan_out_a: assert property (wr_config |=> o_channel_sel == $past(i_wb_dat[2:0])) // [R2]
    else $error("channel select not taken from write");
  start_conv_a: assert property (wr_config |=> o_busy && !done_q && o_conv_start) // [R3]
    else $error("config write did not start conversion");
  high_read_a: assert property (take && !i_wb_we && index == aux_conv_pkg::IDX_HIGH
                                |=> o_wb_ack && o_wb_dat == {24'h000000, $past(result_q[11:4])}) // [R4]
    else $error("high result read wrong");
  low_read_a: assert property (take && !i_wb_we && index == aux_conv_pkg::IDX_LOW
                               |=> o_wb_dat == {24'h000000, $past(result_q[3:0]), $past(done_q), 3'h0}) // [R5]
    else $error("low result read wrong");
  done_flag_a: assert property (o_busy |-> !done_q) // [R6]
    else $error("flag high during conversion");
  finish_set_a: assert property (o_busy && tick && remain_q == 6'h01 && !wr_config && !reset_edge
                                 |=> done_q && !o_busy && result_q == $past(i_conv_result)) // [R7]
    else $error("conversion end did not publish result");
  clock_stop_a: assert property (!ctrl_q.clock_enable ##1 !ctrl_q.clock_enable |-> !o_conv_tick) // [R9]
    else $error("conversion clock ran while disabled");
  reset_pulse_a: assert property (reset_edge |=> o_conv_reset ##1 !o_conv_reset || $past(reset_edge)) // [R10]
    else $error("converter reset pulse wrong");
  no_reset_a: assert property (!reset_edge |=> !o_conv_reset) // [R10]
    else $error("spurious converter reset");

  conv_done_c:  cover property (wr_config ##[1:1000] done_q);
  restart_c:    cover property (o_busy && wr_config);
  reset_abort_c: cover property (o_busy && reset_edge);
  unmapped_c:   cover property (take && index == 8'h10);

endmodule : aux_conv_ctrl

// [bench/aux_conv_ctrl_tb_top.sv]
// self-checking testbench for the auxiliary converter control block
`timescale 1ns/10ps
module aux_conv_ctrl_tb_top;
  // clock, reset and bus drive
  logic        i_clock  = 1'b0;
  logic        i_rst_n  = 1'b0;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [9:0]  wb_adr   = 10'h000;
  logic [3:0]  wb_sel   = 4'h0;
  logic [31:0] wb_wdat  = 32'h0;
  logic [11:0] conv_res = 12'h000;
  // design outputs
  logic        wb_ack;
  logic [31:0] wb_rdat;
  logic [2:0]  chan;
  logic        conv_start;
  logic        conv_reset;
  logic        conv_tick;
  logic        busy;
  // bookkeeping
  int          miscompares = 0;
  int          comparisons = 0;
  int          busy_ticks  = 0;   // ticks seen while a conversion runs
  int          all_ticks   = 0;
  int          starts      = 0;
  int          resets      = 0;
  logic [31:0] rd;
  int          lens [4]    = '{20, 22, 26, 34};

  aux_conv_ctrl aux_conv_ctrl_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
    .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat), .o_wb_ack(wb_ack), .o_wb_dat(wb_rdat),
    .i_conv_result(conv_res), .o_channel_sel(chan), .o_conv_start(conv_start), .o_conv_reset(conv_reset),
    .o_conv_tick(conv_tick), .o_busy(busy)
  );

  // 20 MHz main clock
  always #25 i_clock = ~i_clock;

  // pulse counters, so one-cycle outputs are never missed between bus cycles
  always @(posedge i_clock) begin
    if (conv_tick) all_ticks <= all_ticks + 1;
    if (conv_tick && busy) busy_ticks <= busy_ticks + 1;
    if (conv_start) starts <= starts + 1;
    if (conv_reset) resets <= resets + 1;
  end

  // compare one value and count it
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one classic bus cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d, input logic s0,
                    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_clock);
    {wb_cyc, wb_stb, wb_we} <= {2'b11, we};
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= {3'h0, s0};
    wb_wdat <= {24'h0, d};
    do begin
      @(posedge i_clock);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    check("wb_ack", {31'h0, wb_ack}, 32'h1);
    r = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask : wb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, idx, d, 1'b1, r);
  endtask : wr

  // wait for the running conversion to end, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (busy !== 1'b0 && n < 3000);
    check("busy_end", {31'h0, busy}, 32'h0);
  endtask : wait_idle

  // reset values and an unmapped read
  task automatic t_reset();
    wb(1'b0, 8'h77, 8'h00, 1'b1, rd); check("cfg_rst", rd, 32'h0);
    wb(1'b0, 8'h78, 8'h00, 1'b1, rd); check("high_rst", rd, 32'h0);
    wb(1'b0, 8'h79, 8'h00, 1'b1, rd); check("low_rst", rd, 32'h0);
    wb(1'b0, 8'h10, 8'h00, 1'b1, rd); check("unmapped", rd, 32'h0);
  endtask : t_reset

  // every channel code, read-back, start per write, masked write ignored
  task automatic t_config();
    for (int c = 0; c < 8; c++) begin
      wr(8'h77, {5'h1f, c[2:0]});
      check("chan", {29'h0, chan}, c);
      wb(1'b0, 8'h77, 8'h00, 1'b1, rd); check("cfg_rd", rd, {24'h0, 5'h18, c[2:0]});
      wb(1'b0, 8'h79, 8'h00, 1'b1, rd); check("flag_run", rd, 32'h0);
    end
    check("starts", starts, 8);
    wb(1'b1, 8'h77, 8'h02, 1'b0, rd);
    repeat (2) @(posedge i_clock);
    check("starts_masked", starts, 8);
  endtask : t_config

  // each length code, with results and flag at the end
  task automatic t_lengths();
    logic [11:0] res;
    wr(8'h7a, 8'h87);
    wait_idle();
    for (int l = 0; l < 4; l++) begin
      res = 12'ha5c ^ {l[1:0], 10'h1e7};
      // cleared while idle, so no tick of this conversion can be lost to the clear
      busy_ticks = 0;
      conv_res <= res;
      wr(8'h77, {l[1:0], 6'h03});
      wb(1'b0, 8'h79, 8'h00, 1'b1, rd); check("flag_clr", rd[3], 1'b0);
      wait_idle();
      check("len", busy_ticks, lens[l]);
      wb(1'b0, 8'h78, 8'h00, 1'b1, rd); check("high", rd, {24'h0, res[11:4]});
      wb(1'b0, 8'h79, 8'h00, 1'b1, rd); check("low", rd, {24'h0, res[3:0], 4'h8});
    end
  endtask : t_lengths

  // tick spacing for every divider code
  task automatic t_divider();
    int n;
    for (int d = 0; d < 8; d++) begin
      wr(8'h7a, {5'h10, d[2:0]});
      n = 0;
      do begin @(posedge i_clock); n++; end while (conv_tick !== 1'b1 && n < 600);
      n = 0;
      do begin @(posedge i_clock); n++; end while (conv_tick !== 1'b1 && n < 600);
      check("div_gap", n, 256 >> d);
    end
  endtask : t_divider

  // clock stopped stalls a conversion; enabling finishes it
  task automatic t_enable();
    int snap;
    wr(8'h7a, 8'h07);
    wr(8'h77, 8'h00);
    snap = all_ticks;
    repeat (600) @(posedge i_clock);
    check("no_ticks", all_ticks - snap, 0);
    check("stalled", {31'h0, busy}, 32'h1);
    wr(8'h7a, 8'h87);
    wait_idle();
  endtask : t_enable

  // converter reset on rising bit aborts a conversion, level does not repeat it
  task automatic t_conv_reset();
    wr(8'h77, 8'hc0);
    wr(8'h7a, 8'hc7);
    repeat (2) @(posedge i_clock);
    check("rst_pulse", resets, 1);
    check("aborted", {31'h0, busy}, 32'h0);
    wr(8'h7a, 8'hc7);
    repeat (2) @(posedge i_clock);
    check("rst_level", resets, 1);
    wr(8'h7a, 8'h87);
    wb(1'b0, 8'h79, 8'h00, 1'b1, rd); check("flag_abort", rd[3], 1'b0);
  endtask : t_conv_reset

  // verdict and end of run
  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // watchdog, well beyond the few thousand cycles the tests need
  initial begin
    #(50 * 20000);
    miscompares++;
    print_verdict();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset();
    t_config();
    t_lengths();
    t_divider();
    t_enable();
    t_conv_reset();
    print_verdict();
  end
endmodule : aux_conv_ctrl_tb_top
